// ---- ctlm_defines.vh ----
`ifndef CTLM_DEFINES_VH
`define CTLM_DEFINES_VH
// =========================================
// Major register numbers
`define CTLM_REG_CACHE_OPS 4'h7
`define CTLM_REG_TLB_OPS 4'h8
`define CTLM_REG_CACHE_LOCK 4'h9
`define CTLM_REG_TLB_LOCK 4'ha
`define CTLM_REG_PROC_ID 4'hd
// =========================================
// Minor register / secondary opcode codes
`define CTLM_CRM_0 4'h0
`define CTLM_CRM_1 4'h1
`define CTLM_CRM_5 4'h5
`define CTLM_CRM_6 4'h6
`define CTLM_CRM_7 4'h7
`define CTLM_CRM_10 4'ha
`define CTLM_CRM_13 4'hd
`define CTLM_CRM_14 4'he
`define CTLM_OP2_0 3'h0
`define CTLM_OP2_1 3'h1
`define CTLM_OP2_2 3'h2
`define CTLM_OP2_4 3'h4
// =========================================
// Field positions
`define CTLM_BASE_HI 31
`define CTLM_BASE_LO 26
`define CTLM_TVIC_HI 25
`define CTLM_TVIC_LO 20
`define CTLM_PRES_BIT 0
`define CTLM_SEG_HI 7
`define CTLM_SEG_LO 5
`define CTLM_PID_HI 31
`define CTLM_PID_LO 25
// =========================================
// Reset values and limits
`define CTLM_PTR_ZERO 6'h00
`define CTLM_PTR_ONE 6'h01
`define CTLM_PTR_MAX 6'h3f
`define CTLM_PID_ZERO 7'h00
`define CTLM_WORD_ZERO 32'h0000_0000
`define CTLM_LFSR_SEED 6'h2d
`define CTLM_REGION_BITS 7
`endif

// ---- ctlm_victim_ctr.v ----
`timescale 1ns/1ps
`include "ctlm_defines.vh"
// =========================================
// Victim pointer with base wrap
module ctlm_victim_ctr (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Control
  input wire load_in,
  input wire [5:0] load_val_in,
  input wire advance_in,
  input wire random_in,
  input wire [5:0] base_in,
  // State
  output reg [5:0] victim_out
);
  reg [5:0] lfsr;
  reg [5:0] next_victim;
  reg [5:0] span;
  always @* begin
    span = `CTLM_PTR_MAX - base_in;
    if (random_in) begin
      // Random pick kept inside base..63
      next_victim = base_in + ((span == `CTLM_PTR_MAX) ? lfsr : (lfsr % (span + `CTLM_PTR_ONE)));
    end else if (victim_out >= `CTLM_PTR_MAX || victim_out < base_in) begin
      next_victim = base_in;
    end else begin
      next_victim = victim_out + `CTLM_PTR_ONE;
    end
  end
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      victim_out <= `CTLM_PTR_ZERO;
      lfsr <= `CTLM_LFSR_SEED;
    end else begin
      lfsr <= {lfsr[4:0], lfsr[5] ^ lfsr[4]};
      if (load_in) begin
        victim_out <= load_val_in;
      end else if (advance_in) begin
        victim_out <= next_victim;
      end
    end
  end
endmodule

// ---- ctlm_maint_lockdown.v ----
`timescale 1ns/1ps
`include "ctlm_defines.vh"
module ctlm_maint_lockdown (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Coprocessor transfer from the core
  input wire cp_wr_in,
  input wire cp_rd_in,
  input wire [3:0] cp_major_in,
  input wire [3:0] cp_minor_in,
  input wire [2:0] cp_op2_in,
  input wire [31:0] cp_wdata_in,
  output reg [31:0] cp_rdata_out,
  output wire core_stall_out,
  // Policy and system events
  input wire replacement_policy_select_in,
  input wire interrupt_in,
  input wire wbuf_empty_in,
  input wire instruction_cache_fill_in,
  input wire [2:0] instruction_cache_fill_seg_in,
  input wire data_cache_fill_in,
  input wire [2:0] data_cache_fill_seg_in,
  input wire itlb_fill_in,
  input wire dtlb_fill_in,
  // Address relocation
  input wire [31:0] core_addr_in,
  output wire [31:0] reloc_addr_out,
  // Cache maintenance commands
  output reg instruction_cache_inv_all_out,
  output reg data_cache_inv_all_out,
  output reg instruction_cache_inv_line_out,
  output reg data_cache_inv_line_out,
  output reg instruction_cache_prefetch_out,
  output reg data_cache_clean_out,
  output reg data_cache_clean_inv_out,
  output reg data_cache_by_index_out,
  output reg [31:0] maint_operand_out,
  output reg low_power_out,
  // TLB maintenance commands
  output reg itlb_inv_all_out,
  output reg dtlb_inv_all_out,
  output reg itlb_inv_entry_out,
  output reg dtlb_inv_entry_out,
  // Victim selection
  output wire [5:0] instruction_cache_victim_out,
  output wire [5:0] data_cache_victim_out,
  output wire [5:0] itlb_victim_out,
  output wire [5:0] dtlb_victim_out,
  output wire itlb_fill_preserve_out,
  output wire dtlb_fill_preserve_out
);
  // =========================================
  // State
  localparam ST_RUN = 2'b00;
  localparam ST_DRAIN = 2'b01;
  localparam ST_WAIT = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;
  reg irq_s1;
  reg irq_s2;
  reg [5:0] ic_base;
  reg [5:0] dc_base;
  reg [5:0] itlb_base;
  reg [5:0] dtlb_base;
  reg itlb_pres;
  reg dtlb_pres;
  reg [6:0] process_identifier;
  wire [5:0] ic_vic [0:7];
  wire [5:0] dc_vic [0:7];
  wire [5:0] itlb_vic;
  wire [5:0] dtlb_vic;

  function hit;
    input [3:0] major;
    input [3:0] minor;
    input [2:0] op2;
    input [3:0] want_major;
    input [3:0] want_minor;
    input [2:0] want_op2;
    begin
      hit = (major == want_major) && (minor == want_minor) && (op2 == want_op2);
    end
  endfunction

  wire wr_c7 = cp_wr_in && cp_major_in == `CTLM_REG_CACHE_OPS;
  wire wr_c8 = cp_wr_in && cp_major_in == `CTLM_REG_TLB_OPS;
  wire wr_c9 = cp_wr_in && cp_major_in == `CTLM_REG_CACHE_LOCK;
  wire wr_c10 = cp_wr_in && cp_major_in == `CTLM_REG_TLB_LOCK;
  wire wr_c13 = cp_wr_in && cp_major_in == `CTLM_REG_PROC_ID;
  wire c9_full = wr_c9 && cp_minor_in == `CTLM_CRM_0;
  wire c9_seg = wr_c9 && cp_minor_in == `CTLM_CRM_1;
  wire sel_d = cp_op2_in == `CTLM_OP2_0;
  wire sel_i = cp_op2_in == `CTLM_OP2_1;
  wire [5:0] wr_base = cp_wdata_in[`CTLM_BASE_HI:`CTLM_BASE_LO];
  wire [2:0] wr_seg = cp_wdata_in[`CTLM_SEG_HI:`CTLM_SEG_LO];
  wire do_drain = wr_c7 && hit(cp_major_in, cp_minor_in, cp_op2_in,
    `CTLM_REG_CACHE_OPS, `CTLM_CRM_10, `CTLM_OP2_4);
  wire do_wait = wr_c7 && hit(cp_major_in, cp_minor_in, cp_op2_in,
    `CTLM_REG_CACHE_OPS, `CTLM_CRM_0, `CTLM_OP2_4);

  // =========================================
  // Interrupt synchroniser
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
    end else begin
      irq_s1 <= interrupt_in;
      irq_s2 <= irq_s1;
    end
  end

  // =========================================
  // Stall sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (do_drain) begin
          next_state = ST_DRAIN;
        end else if (do_wait) begin
          next_state = ST_WAIT;
        end
      end
      ST_DRAIN: begin
        if (wbuf_empty_in) begin
          next_state = ST_RUN;
        end
      end
      ST_WAIT: begin
        if (irq_s2) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end
  // Stall is combinational so the core holds in the command's next cycle
  assign core_stall_out = (state != ST_RUN) && (next_state != ST_RUN);
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state <= ST_RUN;
      low_power_out <= 1'b0;
    end else begin
      state <= next_state;
      low_power_out <= (next_state == ST_WAIT);
    end
  end

  // =========================================
  // Maintenance command decode, one-cycle pulses
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      instruction_cache_inv_all_out <= 1'b0;
      data_cache_inv_all_out <= 1'b0;
      instruction_cache_inv_line_out <= 1'b0;
      data_cache_inv_line_out <= 1'b0;
      instruction_cache_prefetch_out <= 1'b0;
      data_cache_clean_out <= 1'b0;
      data_cache_clean_inv_out <= 1'b0;
      data_cache_by_index_out <= 1'b0;
      maint_operand_out <= `CTLM_WORD_ZERO;
      itlb_inv_all_out <= 1'b0;
      dtlb_inv_all_out <= 1'b0;
      itlb_inv_entry_out <= 1'b0;
      dtlb_inv_entry_out <= 1'b0;
    end else begin
      instruction_cache_inv_all_out <= wr_c7 && cp_op2_in == `CTLM_OP2_0 &&
        (cp_minor_in == `CTLM_CRM_7 || cp_minor_in == `CTLM_CRM_5);
      data_cache_inv_all_out <= wr_c7 && cp_op2_in == `CTLM_OP2_0 &&
        (cp_minor_in == `CTLM_CRM_7 || cp_minor_in == `CTLM_CRM_6);
      instruction_cache_inv_line_out <= wr_c7 && hit(cp_major_in, cp_minor_in, cp_op2_in,
        `CTLM_REG_CACHE_OPS, `CTLM_CRM_5, `CTLM_OP2_1);
      data_cache_inv_line_out <= wr_c7 && hit(cp_major_in, cp_minor_in, cp_op2_in,
        `CTLM_REG_CACHE_OPS, `CTLM_CRM_6, `CTLM_OP2_1);
      instruction_cache_prefetch_out <= wr_c7 && hit(cp_major_in, cp_minor_in, cp_op2_in,
        `CTLM_REG_CACHE_OPS, `CTLM_CRM_13, `CTLM_OP2_1);
      // Clean and clean-invalidate share the address/index select
      data_cache_clean_out <= wr_c7 && cp_minor_in == `CTLM_CRM_10 &&
        (sel_i || cp_op2_in == `CTLM_OP2_2);
      data_cache_clean_inv_out <= wr_c7 && cp_minor_in == `CTLM_CRM_14 &&
        (sel_i || cp_op2_in == `CTLM_OP2_2);
      data_cache_by_index_out <= wr_c7 && cp_op2_in == `CTLM_OP2_2;
      if (wr_c7 || wr_c8) begin
        maint_operand_out <= cp_wdata_in;
      end
      itlb_inv_all_out <= wr_c8 && sel_d &&
        (cp_minor_in == `CTLM_CRM_7 || cp_minor_in == `CTLM_CRM_5);
      dtlb_inv_all_out <= wr_c8 && sel_d &&
        (cp_minor_in == `CTLM_CRM_7 || cp_minor_in == `CTLM_CRM_6);
      itlb_inv_entry_out <= wr_c8 && sel_i && cp_minor_in == `CTLM_CRM_5;
      dtlb_inv_entry_out <= wr_c8 && sel_i && cp_minor_in == `CTLM_CRM_6;
    end
  end

  // =========================================
  // Lockdown and identifier registers
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ic_base <= `CTLM_PTR_ZERO;
      dc_base <= `CTLM_PTR_ZERO;
      itlb_base <= `CTLM_PTR_ZERO;
      dtlb_base <= `CTLM_PTR_ZERO;
      itlb_pres <= 1'b0;
      dtlb_pres <= 1'b0;
      process_identifier <= `CTLM_PID_ZERO;
    end else begin
      if (c9_full && sel_i) begin
        ic_base <= wr_base;
      end
      if (c9_full && sel_d) begin
        dc_base <= wr_base;
      end
      if (wr_c10 && sel_i) begin
        itlb_base <= wr_base;
        itlb_pres <= cp_wdata_in[`CTLM_PRES_BIT];
      end
      if (wr_c10 && sel_d) begin
        dtlb_base <= wr_base;
        dtlb_pres <= cp_wdata_in[`CTLM_PRES_BIT];
      end
      if (wr_c13) begin
        process_identifier <= cp_wdata_in[`CTLM_PID_HI:`CTLM_PID_LO];
      end
    end
  end

  // =========================================
  // Cache victim counters, one per segment
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : seg
      ctlm_victim_ctr u_ic (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .load_in(sel_i && (c9_full || (c9_seg && wr_seg == g))),
        .load_val_in(wr_base),
        .advance_in(instruction_cache_fill_in && instruction_cache_fill_seg_in == g),
        .random_in(!replacement_policy_select_in),
        .base_in(ic_base),
        .victim_out(ic_vic[g])
      );
      ctlm_victim_ctr u_dc (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .load_in(sel_d && (c9_full || (c9_seg && wr_seg == g))),
        .load_val_in(wr_base),
        .advance_in(data_cache_fill_in && data_cache_fill_seg_in == g),
        .random_in(!replacement_policy_select_in),
        .base_in(dc_base),
        .victim_out(dc_vic[g])
      );
    end
  endgenerate
  // Victim shown is the one the pending fill uses before it advances
  assign instruction_cache_victim_out = ic_vic[instruction_cache_fill_seg_in];
  assign data_cache_victim_out = dc_vic[data_cache_fill_seg_in];

  // =========================================
  // TLB victim counters, always round-robin
  // Below the base a TLB victim keeps counting up; only 63 reloads the base
  ctlm_victim_ctr u_itlb (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .load_in(wr_c10 && sel_i),
    .load_val_in(cp_wdata_in[`CTLM_TVIC_HI:`CTLM_TVIC_LO]),
    .advance_in(itlb_fill_in),
    .random_in(1'b0),
    .base_in(itlb_vic < itlb_base ? `CTLM_PTR_ZERO : itlb_base),
    .victim_out(itlb_vic)
  );
  ctlm_victim_ctr u_dtlb (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .load_in(wr_c10 && sel_d),
    .load_val_in(cp_wdata_in[`CTLM_TVIC_HI:`CTLM_TVIC_LO]),
    .advance_in(dtlb_fill_in),
    .random_in(1'b0),
    .base_in(dtlb_vic < dtlb_base ? `CTLM_PTR_ZERO : dtlb_base),
    .victim_out(dtlb_vic)
  );
  assign itlb_victim_out = itlb_vic;
  assign dtlb_victim_out = dtlb_vic;
  assign itlb_fill_preserve_out = itlb_pres;
  assign dtlb_fill_preserve_out = dtlb_pres;

  // =========================================
  // Read data, registered; undefined low bits read as zero
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cp_rdata_out <= `CTLM_WORD_ZERO;
    end else if (cp_rd_in) begin
      case (cp_major_in)
        `CTLM_REG_CACHE_LOCK: begin
          cp_rdata_out <= {sel_i ? ic_base : dc_base, 26'h0};
        end
        `CTLM_REG_TLB_LOCK: begin
          cp_rdata_out <= sel_i ? {itlb_base, itlb_vic, 19'h0, itlb_pres} :
            {dtlb_base, dtlb_vic, 19'h0, dtlb_pres};
        end
        `CTLM_REG_PROC_ID: begin
          cp_rdata_out <= {process_identifier, 25'h0};
        end
        // Command registers read as zero; software never reads them
        default: begin
          cp_rdata_out <= `CTLM_WORD_ZERO;
        end
      endcase
    end
  end

  // =========================================
  // Low-region relocation by identifier
  wire low_region = core_addr_in[`CTLM_PID_HI:`CTLM_PID_LO] == `CTLM_PID_ZERO;
  assign reloc_addr_out = low_region ?
    {process_identifier, core_addr_in[`CTLM_PID_LO-1:0]} : core_addr_in;
endmodule

// ---- ctlm_maint_lockdown_properties.sv ----
`timescale 1ns/1ps
// ==========
// Port checker
module ctlm_props (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Inputs
  input wire cp_wr_in,
  input wire [3:0] cp_major_in,
  input wire [3:0] cp_minor_in,
  input wire [2:0] cp_op2_in,
  input wire [31:0] cp_wdata_in,
  input wire wbuf_empty_in,
  input wire interrupt_in,
  input wire itlb_fill_in,
  input wire [31:0] core_addr_in,
  // Outputs
  input wire [31:0] reloc_addr_out,
  input wire [31:0] maint_operand_out,
  input wire core_stall_out,
  input wire low_power_out,
  input wire instruction_cache_inv_all_out,
  input wire data_cache_inv_all_out,
  input wire data_cache_inv_line_out,
  input wire data_cache_by_index_out,
  input wire itlb_inv_entry_out,
  input wire [5:0] itlb_victim_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire [10:0] code = {cp_major_in, cp_minor_in, cp_op2_in};
  wire cmd_wr = cp_wr_in;
  inv_all_a: assert property (cmd_wr && code == 11'h3b8 |=>
    instruction_cache_inv_all_out && data_cache_inv_all_out) else $error("whole invalidate missing");
  line_inv_a: assert property (cmd_wr && code == 11'h3b1 |=>
    data_cache_inv_line_out && maint_operand_out == $past(cp_wdata_in))
    else $error("line invalidate missing");
  index_clean_a: assert property (cmd_wr && code == 11'h3f2 |=>
    data_cache_by_index_out && !data_cache_inv_line_out) else $error("index clean wrong");
  drain_stall_a: assert property (cmd_wr && code == 11'h3d4 ##1 !wbuf_empty_in
    |-> core_stall_out) else $error("no stall while draining");
  wait_halt_a: assert property (!interrupt_in ##1 cmd_wr && code == 11'h384 |=>
    low_power_out && core_stall_out) else $error("wait did not halt");
  tlb_entry_a: assert property (cmd_wr && code == 11'h429 |=>
    itlb_inv_entry_out) else $error("tlb entry invalidate missing");
  idle_quiet_a: assert property (!cmd_wr |=>
    !instruction_cache_inv_all_out && !data_cache_inv_line_out && !itlb_inv_entry_out)
    else $error("pulse without command");
  tlb_step_a: assert property (itlb_fill_in && !cmd_wr && itlb_victim_out != 6'h3f
    |=> itlb_victim_out == $past(itlb_victim_out) + 6'h01) else $error("tlb victim step");
  high_pass_a: assert property (core_addr_in[31:25] != 7'h00
    |-> reloc_addr_out == core_addr_in) else $error("high address altered");
  cover property (cmd_wr && code == 11'h3d4);
  cover property (low_power_out);
  cover property (itlb_fill_in && itlb_victim_out == 6'h3f);
endmodule
bind ctlm_maint_lockdown ctlm_props u_props (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cp_wr_in(cp_wr_in),
  .cp_major_in(cp_major_in), .cp_minor_in(cp_minor_in), .cp_op2_in(cp_op2_in),
  .cp_wdata_in(cp_wdata_in), .wbuf_empty_in(wbuf_empty_in), .itlb_fill_in(itlb_fill_in),
  .core_addr_in(core_addr_in), .reloc_addr_out(reloc_addr_out),
  .maint_operand_out(maint_operand_out), .core_stall_out(core_stall_out),
  .low_power_out(low_power_out), .instruction_cache_inv_all_out(instruction_cache_inv_all_out),
  .interrupt_in(interrupt_in),
  .data_cache_inv_all_out(data_cache_inv_all_out), .data_cache_inv_line_out(data_cache_inv_line_out),
  .data_cache_by_index_out(data_cache_by_index_out), .itlb_inv_entry_out(itlb_inv_entry_out),
  .itlb_victim_out(itlb_victim_out));

// ---- ctlm_core_model.sv ----
`timescale 1ns/1ps
// ==========
// Core side of the coprocessor port
module ctlm_core_model (
  // Clock
  input wire ref_clk_in,
  // Transfer
  input wire [31:0] cp_rdata_in,
  output reg cp_wr_out = 1'b0,
  output reg cp_rd_out = 1'b0,
  output reg [3:0] cp_major_out = 4'h0,
  output reg [3:0] cp_minor_out = 4'h0,
  output reg [2:0] cp_op2_out = 3'h0,
  output reg [31:0] cp_wdata_out = 32'h0
);
  task wr(input [3:0] maj, input [3:0] mnr, input [2:0] op, input [31:0] dat);
    reg [31:0] w;
    begin
      w = dat;
      if (maj == 4'h9 && mnr == 4'h0) w = {dat[31:26], 26'h0};
      if (maj == 4'ha) w = {dat[31:20], 19'h0, dat[0]};
      if (maj == 4'hd) w = {dat[31:25], 25'h0};
      @(posedge ref_clk_in);
      cp_wr_out <= 1'b1;
      cp_major_out <= maj;
      cp_minor_out <= mnr;
      cp_op2_out <= op;
      cp_wdata_out <= w;
      @(posedge ref_clk_in);
      cp_wr_out <= 1'b0;
      // Released data never keeps the old word
      cp_wdata_out <= ~w;
    end
  endtask
  task rd(input [3:0] maj, input [2:0] op, output [31:0] dat);
    begin
      dat = 32'h0;
      if (maj != 4'h7 && maj != 4'h8) begin
        @(posedge ref_clk_in);
        cp_rd_out <= 1'b1;
        cp_major_out <= maj;
        cp_minor_out <= 4'h0;
        cp_op2_out <= op;
        @(posedge ref_clk_in);
        cp_rd_out <= 1'b0;
        @(posedge ref_clk_in);
        dat = cp_rdata_in;
      end
    end
  endtask
endmodule

// ---- ctlm_maint_lockdown_tb.sv ----
`timescale 1ns/1ps
// ==========
// Self-checking bench
module ctlm_maint_lockdown_tb;
  reg ref_clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg pol = 1'b1;
  reg irq = 1'b0;
  reg wbe = 1'b1;
  reg [3:0] fl = 4'h0;
  reg [2:0] iseg = 3'h3;
  reg [2:0] dseg = 3'h5;
  reg [31:0] addr = 32'h0;
  wire cwr, crd, stall, lp, ip, dp;
  wire [3:0] maj, mnr;
  wire [2:0] op;
  wire [31:0] wd, rdat, reloc, opnd;
  wire [11:0] pl;
  wire [5:0] iv, dv, itv, dtv;
  integer errors = 0;
  integer check_count = 0;
  integer i, v, w;
  reg [31:0] seed = 32'd37729;
  reg [31:0] d, p;
  reg [22:0] tab [0:15];
  ctlm_core_model core (.ref_clk_in(ref_clk_in), .cp_rdata_in(rdat), .cp_wr_out(cwr),
    .cp_rd_out(crd), .cp_major_out(maj), .cp_minor_out(mnr), .cp_op2_out(op),
    .cp_wdata_out(wd));
  ctlm_maint_lockdown DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cp_wr_in(cwr),
    .cp_rd_in(crd), .cp_major_in(maj), .cp_minor_in(mnr), .cp_op2_in(op), .cp_wdata_in(wd),
    .cp_rdata_out(rdat), .core_stall_out(stall), .replacement_policy_select_in(pol),
    .interrupt_in(irq), .wbuf_empty_in(wbe), .instruction_cache_fill_in(fl[3]),
    .instruction_cache_fill_seg_in(iseg), .data_cache_fill_in(fl[2]), .data_cache_fill_seg_in(dseg),
    .itlb_fill_in(fl[1]), .dtlb_fill_in(fl[0]), .core_addr_in(addr), .reloc_addr_out(reloc),
    .instruction_cache_inv_all_out(pl[11]), .data_cache_inv_all_out(pl[10]), .instruction_cache_inv_line_out(pl[9]),
    .data_cache_inv_line_out(pl[8]), .instruction_cache_prefetch_out(pl[7]), .data_cache_clean_out(pl[6]),
    .data_cache_clean_inv_out(pl[5]), .data_cache_by_index_out(pl[4]), .maint_operand_out(opnd),
    .low_power_out(lp), .itlb_inv_all_out(pl[3]), .dtlb_inv_all_out(pl[2]),
    .itlb_inv_entry_out(pl[1]), .dtlb_inv_entry_out(pl[0]), .instruction_cache_victim_out(iv),
    .data_cache_victim_out(dv), .itlb_victim_out(itv), .dtlb_victim_out(dtv),
    .itlb_fill_preserve_out(ip), .dtlb_fill_preserve_out(dp));
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task end_sim;
    begin
      if (errors == 0 && check_count > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  task fill(input c, input t);
    begin
      @(posedge ref_clk_in);
      fl <= {c, c, t, t};
      @(posedge ref_clk_in);
      fl <= 4'h0;
      #1;
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    tab = '{23'h3b8c00, 23'h3a8800, 23'h3b0400, 23'h3a9200, 23'h3b1100, 23'h3e9080,
      23'h3d1040, 23'h3f1020, 23'h3d2050, 23'h3f2030, 23'h43800c, 23'h428008,
      23'h430004, 23'h429002, 23'h431001, 23'h398000};
    repeat (16) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      core.rd(i < 2 ? 4'h9 : (i < 4 ? 4'ha : 4'hd), {2'b00, i[0] & (i < 4)}, d);
      chk("reset_value", d, 32'h0);
    end
    for (i = 0; i < 16; i = i + 1) begin
      seed = xs(seed);
      core.wr(tab[i][22:19], tab[i][18:15], tab[i][14:12], seed);
      #1;
      chk("pulses", {20'h0, pl}, {20'h0, tab[i][11:0]});
      if (tab[i][11:0] != 12'h000) chk("operand", opnd, seed);
      @(posedge ref_clk_in);
      #1;
      chk("pulse_end", {20'h0, pl}, 32'h0);
    end
    core.wr(4'h9, 4'h0, 3'h0, {6'd60, 26'h0});
    core.wr(4'h9, 4'h0, 3'h1, {6'd60, 26'h0});
    core.rd(4'h9, 3'h1, d);
    chk("cache_base", d, {6'd60, 26'h0});
    v = 60;
    for (i = 0; i < 6; i = i + 1) begin
      chk("instruction_cache_victim", {26'h0, iv}, v);
      chk("data_cache_victim", {26'h0, dv}, v);
      fill(1'b1, 1'b0);
      v = (v == 63) ? 60 : v + 1;
    end
    pol <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      fill(1'b1, 1'b0);
      chk("random_range", {31'h0, iv >= 6'd60}, 32'h1);
    end
    core.wr(4'h9, 4'h1, 3'h1, {6'd10, 18'h0, 3'h2, 5'h0});
    iseg <= 3'h2;
    @(posedge ref_clk_in);
    #1;
    chk("debug_victim", {26'h0, iv}, 32'd10);
    iseg <= 3'h4;
    @(posedge ref_clk_in);
    #1;
    chk("other_segment", {26'h0, iv}, 32'd60);
    core.wr(4'ha, 4'h0, 3'h1, {6'd61, 6'd62, 19'h0, 1'b1});
    core.wr(4'ha, 4'h0, 3'h0, {6'd2, 6'd0, 19'h0, 1'b0});
    core.rd(4'ha, 3'h1, d);
    chk("tlb_lock", d, {6'd61, 6'd62, 19'h0, 1'b1});
    chk("preserve", {30'h0, ip, dp}, 32'h2);
    v = 62;
    w = 0;
    for (i = 0; i < 5; i = i + 1) begin
      chk("itlb_victim", {26'h0, itv}, v);
      chk("dtlb_victim", {26'h0, dtv}, w);
      fill(1'b0, 1'b1);
      v = (v == 63) ? 61 : v + 1;
      w = w + 1;
    end
    seed = xs(seed);
    core.wr(4'hd, 4'h0, 3'h0, seed);
    p = {seed[31:25], 25'h0};
    core.rd(4'hd, 3'h0, d);
    chk("process_id", d, p);
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      d = i[0] ? seed : {7'h00, seed[24:0]};
      @(posedge ref_clk_in);
      addr <= d;
      #1;
      chk("relocated", reloc, d < 32'h0200_0000 ? d + p : d);
    end
    @(posedge ref_clk_in);
    wbe <= 1'b0;
    core.wr(4'h7, 4'ha, 3'h4, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      #1;
      chk("drain_stall", {31'h0, stall}, 32'h1);
      @(posedge ref_clk_in);
    end
    wbe <= 1'b1;
    #1;
    chk("drain_done", {31'h0, stall}, 32'h0);
    core.wr(4'h7, 4'h0, 3'h4, 32'h0);
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk("wait_state", {30'h0, lp, stall}, 32'h3);
    @(posedge ref_clk_in);
    irq <= 1'b1;
    i = 0;
    while (lp !== 1'b0 && i < 8) begin
      @(posedge ref_clk_in);
      #1;
      i = i + 1;
    end
    if (i == 8) begin
      errors = errors + 1;
      end_sim;
    end
    chk("wake_stall", {31'h0, stall}, 32'h0);
    end_sim;
  end
endmodule
